//--- fsc_pkg.sv
package fsc_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_TACH_MODE_RES = 8'hBD;
   localparam logic [7:0] ADDR_THRESH_SEL = 8'hBE;
   localparam logic [7:0] ADDR_RAMP_DELAY = 8'hBF;
   localparam logic [7:0] ADDR_HYST_A = 8'hC0;
   localparam logic [7:0] ADDR_HYST_B = 8'hC1;
   localparam logic [7:0] ADDR_SPIKE_CTRL = 8'hC2;

   // -------------------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------------------
   localparam logic [7:0] RST_TACH_MODE_RES = 8'h00;
   localparam logic [7:0] RST_THRESH_SEL = 8'h00;
   localparam logic [7:0] RST_RAMP_DELAY = 8'h00;
   localparam logic [7:0] RST_HYST_A = 8'h00;
   localparam logic [7:0] RST_HYST_B = 8'h44;
   localparam logic [7:0] RST_SPIKE_CTRL = 8'h00;
   localparam logic [7:0] MASK_TACH_MODE_RES = 8'h3F;
   localparam logic [7:0] MASK_THRESH_SEL = 8'hF3;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int SMART_TACH_LSB = 0;
   localparam int HALF_DEG_ONE_BIT = 4;
   localparam int HALF_DEG_TWO_BIT = 5;
   localparam int CPU_A_VID_BIT = 0;
   localparam int CPU_B_VID_BIT = 1;
   localparam int GP_IN_LSB = 4;
   localparam int REG_HOT_LSB = 0;
   localparam int THROTTLE_LSB = 4;
   localparam int HYST_LO_LSB = 0;
   localparam int HYST_HI_LSB = 4;
   localparam int SPAN_ONE_LSB = 0;
   localparam int USE_ONE_BIT = 3;
   localparam int SPAN_TWO_LSB = 4;
   localparam int USE_TWO_BIT = 7;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLOCK_HZ = 40000000;
   localparam int RAMP_UNIT_MS = 50;
   localparam int RAMP_UNIT_CYCLES = RAMP_UNIT_MS * (CLOCK_HZ / 1000);

   // smoothing spans in tenths of a second, codes 0 to 7
   localparam int SPAN_DS_0 = 118;
   localparam int SPAN_DS_7 = 4;

   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [7:0] DUTY_ZERO = 8'h00;

   typedef enum logic [2:0] {
      FSC_RAMP_HOLD = 3'b001,
      FSC_RAMP_UP = 3'b010,
      FSC_RAMP_DOWN = 3'b100
   } fsc_ramp_state_t;
endpackage

//--- fsc_ramp_step.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_ramp_step (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic hot_in,
   input wire logic [3:0] step_code,
   input wire logic unit_tick,
   output logic [7:0] duty_out,
   output logic ramp_busy
);
   fsc_pkg::fsc_ramp_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] duty_q, duty_d;
   wire zero_delay = (step_code == 4'h0);
   wire step_due = unit_tick && ((cnt_q + 4'h1) >= step_code);
   wire at_full = (duty_q == fsc_pkg::DUTY_FULL);
   wire at_zero = (duty_q == fsc_pkg::DUTY_ZERO);

   // -------------------------------------------------------------
   // direction state
   // -------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         fsc_pkg::FSC_RAMP_HOLD: begin
            if (hot_in && !at_full) begin
               state_d = fsc_pkg::FSC_RAMP_UP;
            end else if (!hot_in && !at_zero) begin
               state_d = fsc_pkg::FSC_RAMP_DOWN;
            end
         end
         fsc_pkg::FSC_RAMP_UP: begin
            if (!hot_in) begin
               state_d = fsc_pkg::FSC_RAMP_DOWN;
            end else if (at_full) begin
               state_d = fsc_pkg::FSC_RAMP_HOLD;
            end
         end
         fsc_pkg::FSC_RAMP_DOWN: begin
            if (hot_in) begin
               state_d = fsc_pkg::FSC_RAMP_UP;
            end else if (at_zero) begin
               state_d = fsc_pkg::FSC_RAMP_HOLD;
            end
         end
         default: state_d = fsc_pkg::FSC_RAMP_HOLD;
      endcase
   end

   // -------------------------------------------------------------
   // duty stepping, one step per code times 50 ms
   // -------------------------------------------------------------
   always_comb begin
      duty_d = duty_q;
      cnt_d = cnt_q;
      if (zero_delay) begin
         duty_d = hot_in ? fsc_pkg::DUTY_FULL : fsc_pkg::DUTY_ZERO;
         cnt_d = 4'h0;
      end else if (state_q == fsc_pkg::FSC_RAMP_HOLD || state_d != state_q) begin
         cnt_d = 4'h0;
      end else if (unit_tick) begin
         cnt_d = step_due ? 4'h0 : cnt_q + 4'h1;
         if (step_due && state_q == fsc_pkg::FSC_RAMP_UP && !at_full) begin
            duty_d = duty_q + 8'h01;
         end else if (step_due && state_q == fsc_pkg::FSC_RAMP_DOWN && !at_zero) begin
            duty_d = duty_q - 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= fsc_pkg::FSC_RAMP_HOLD;
         cnt_q <= 4'h0;
         duty_q <= fsc_pkg::DUTY_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         duty_q <= duty_d;
      end
   end

   assign duty_out = duty_q;
   assign ramp_busy = (state_q != fsc_pkg::FSC_RAMP_HOLD);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   chk_zero_delay_full: assert property (@(posedge clock) disable iff (!rst_b)
      (hot_in && zero_delay) |=> (duty_q == fsc_pkg::DUTY_FULL))
      else $error("zero delay did not jump to full duty");
   chk_step_needs_tick: assert property (@(posedge clock) disable iff (!rst_b)
      (duty_q == $past(duty_q) + 8'h01) && !$past(zero_delay) |-> $past(unit_tick))
      else $error("duty stepped without a delay unit");
endmodule // fsc_ramp_step
`default_nettype wire

//--- fsc_setup_regs.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_setup_regs #(
   parameter int RAMP_UNIT_CYCLES = fsc_pkg::RAMP_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [3:0] smart_tach_en,
   output logic cpu_a_vid_low_thresh,
   output logic cpu_b_vid_low_thresh,
   output logic [3:0] gp_in_low_thresh,
   input wire logic [1:0] regulator_hot_input,
   input wire logic [1:0] cpu_throttle_signal,
   output logic [7:0] regulator_hot_duty,
   output logic [7:0] throttle_duty,
   input wire logic [35:0] zone_temp,
   input wire logic [31:0] boost_temp,
   input wire logic temp_valid,
   input wire logic limit_filter_sel_one,
   input wire logic limit_filter_sel_two,
   input wire logic fanctl_filter_sel_one,
   input wire logic fanctl_filter_sel_two,
   output logic [35:0] fanctl_temp,
   output logic [17:0] limit_temp,
   output logic [17:0] reading_temp,
   output logic [17:0] filtered_temp,
   output logic [3:0] boost_full_duty
);
   localparam int TICK_W = $clog2(RAMP_UNIT_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(RAMP_UNIT_CYCLES - 1);

   // -------------------------------------------------------------
   // register storage and helpers
   // -------------------------------------------------------------
   logic [7:0] tach_res_q, thresh_q, ramp_q, hyst_a_q, hyst_b_q, spike_q;
   logic [7:0] rdata_q, rdata_d;
   logic [TICK_W-1:0] tick_cnt_q;
   logic unit_tick_q;
   logic [3:0] boost_q, boost_d;
   logic [15:0] acc_q [2];
   logic [15:0] acc_d [2];

   // masked write keeps reserved bits at zero
   function automatic logic [7:0] wr_merge(input logic [7:0] data, input logic [7:0] mask);
      wr_merge = data & mask;
   endfunction

   // smoothing shift per span code: larger shift, longer averaging
   function automatic logic [2:0] span_shift(input logic [2:0] code);
      case (code)
         3'h0: span_shift = 3'h7;
         3'h1: span_shift = 3'h6;
         3'h2: span_shift = 3'h6;
         3'h3: span_shift = 3'h5;
         3'h4: span_shift = 3'h4;
         3'h5: span_shift = 3'h3;
         3'h6: span_shift = 3'h3;
         default: span_shift = 3'h2;
      endcase
   endfunction

   // boost temperature minus hysteresis, floored at zero
   function automatic logic [7:0] release_level(input logic [7:0] boost, input logic [3:0] hyst);
      release_level = (boost > {4'h0, hyst}) ? boost - {4'h0, hyst} : 8'h00;
   endfunction

   // one filter step; rising steps round up so a steady input is reached exactly
   function automatic logic [15:0] smooth_step(input logic [15:0] acc, input logic [8:0] temp,
                                               input logic [2:0] sh);
      logic signed [16:0] diff;
      diff = signed'({1'b0, temp, 7'h00}) - signed'({1'b0, acc});
      if (diff > 17'sh0) begin
         diff = diff + ((17'sh1 <<< sh) - 17'sh1);
      end
      smooth_step = 16'(signed'({1'b0, acc}) + (diff >>> sh));
   endfunction

   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   wire hit_tach = (reg_addr == fsc_pkg::ADDR_TACH_MODE_RES);
   wire hit_thresh = (reg_addr == fsc_pkg::ADDR_THRESH_SEL);
   wire hit_ramp = (reg_addr == fsc_pkg::ADDR_RAMP_DELAY);
   wire hit_hyst_a = (reg_addr == fsc_pkg::ADDR_HYST_A);
   wire hit_hyst_b = (reg_addr == fsc_pkg::ADDR_HYST_B);
   wire hit_spike = (reg_addr == fsc_pkg::ADDR_SPIKE_CTRL);

   // -------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tach_res_q <= fsc_pkg::RST_TACH_MODE_RES;
         thresh_q <= fsc_pkg::RST_THRESH_SEL;
         ramp_q <= fsc_pkg::RST_RAMP_DELAY;
         hyst_a_q <= fsc_pkg::RST_HYST_A;
         hyst_b_q <= fsc_pkg::RST_HYST_B;
         spike_q <= fsc_pkg::RST_SPIKE_CTRL;
      end else if (reg_wr) begin
         if (hit_tach) begin
            tach_res_q <= wr_merge(reg_wdata, fsc_pkg::MASK_TACH_MODE_RES);
         end else if (hit_thresh) begin
            thresh_q <= wr_merge(reg_wdata, fsc_pkg::MASK_THRESH_SEL);
         end else if (hit_ramp) begin
            ramp_q <= reg_wdata;
         end else if (hit_hyst_a) begin
            hyst_a_q <= reg_wdata;
         end else if (hit_hyst_b) begin
            hyst_b_q <= reg_wdata;
         end else if (hit_spike) begin
            spike_q <= reg_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // read path, unmapped offsets read zero
   // -------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (hit_tach) begin
         rdata_d = tach_res_q;
      end else if (hit_thresh) begin
         rdata_d = thresh_q;
      end else if (hit_ramp) begin
         rdata_d = ramp_q;
      end else if (hit_hyst_a) begin
         rdata_d = hyst_a_q;
      end else if (hit_hyst_b) begin
         rdata_d = hyst_b_q;
      end else if (hit_spike) begin
         rdata_d = spike_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // -------------------------------------------------------------
   // control exports
   // -------------------------------------------------------------
   assign smart_tach_en = tach_res_q[fsc_pkg::SMART_TACH_LSB +: 4];
   assign cpu_a_vid_low_thresh = thresh_q[fsc_pkg::CPU_A_VID_BIT];
   assign cpu_b_vid_low_thresh = thresh_q[fsc_pkg::CPU_B_VID_BIT];
   assign gp_in_low_thresh = thresh_q[fsc_pkg::GP_IN_LSB +: 4];

   // -------------------------------------------------------------
   // 50 ms delay unit shared by both ramps
   // -------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tick_cnt_q <= '0;
         unit_tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + TICK_W'(1);
         unit_tick_q <= (tick_cnt_q == TICK_LAST);
      end
   end

   // -------------------------------------------------------------
   // ramp engines
   // -------------------------------------------------------------
   wire [3:0] regulator_hot_step_delay = ramp_q[fsc_pkg::REG_HOT_LSB +: 4];
   wire [3:0] throttle_step_delay = ramp_q[fsc_pkg::THROTTLE_LSB +: 4];

   fsc_ramp_step u_reg_hot_ramp (
      .clock(clock),
      .rst_b(rst_b),
      .hot_in(|regulator_hot_input),
      .step_code(regulator_hot_step_delay),
      .unit_tick(unit_tick_q),
      .duty_out(regulator_hot_duty),
      .ramp_busy()
   );

   fsc_ramp_step u_throttle_ramp (
      .clock(clock),
      .rst_b(rst_b),
      .hot_in(|cpu_throttle_signal),
      .step_code(throttle_step_delay),
      .unit_tick(unit_tick_q),
      .duty_out(throttle_duty),
      .ramp_busy()
   );

   // -------------------------------------------------------------
   // fan boost with per-zone hysteresis, temperatures in whole degrees
   // -------------------------------------------------------------
   wire [35:0] boost_src; // zones 1 and 2 follow the fan control filter choice
   wire [15:0] hyst_all = {hyst_b_q, hyst_a_q};
   always_comb begin
      boost_d = boost_q;
      for (int z = 0; z < 4; z++) begin
         if (boost_src[z*9+1 +: 8] > boost_temp[z*8 +: 8]) begin
            boost_d[z] = 1'b1;
         end else if (boost_src[z*9+1 +: 8] < release_level(boost_temp[z*8 +: 8], hyst_all[z*4 +: 4])) begin
            boost_d[z] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         boost_q <= 4'h0;
      end else begin
         boost_q <= boost_d;
      end
   end
   assign boost_full_duty = boost_q;

   // -------------------------------------------------------------
   // spike smoothing, extra averaging on each new conversion
   // -------------------------------------------------------------
   wire [2:0] smoothing_span_zone_one = spike_q[fsc_pkg::SPAN_ONE_LSB +: 3];
   wire [2:0] smoothing_span_zone_two = spike_q[fsc_pkg::SPAN_TWO_LSB +: 3];
   wire smoothing_use_zone_one = spike_q[fsc_pkg::USE_ONE_BIT];
   wire smoothing_use_zone_two = spike_q[fsc_pkg::USE_TWO_BIT];
   wire [2:0] shift_sel [2];
   assign shift_sel[0] = span_shift(smoothing_span_zone_one);
   assign shift_sel[1] = span_shift(smoothing_span_zone_two);

   always_comb begin
      for (int z = 0; z < 2; z++) begin
         acc_d[z] = acc_q[z];
         if (temp_valid) begin
            acc_d[z] = smooth_step(acc_q[z], zone_temp[z*9 +: 9], shift_sel[z]);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         acc_q[0] <= 16'h0000;
         acc_q[1] <= 16'h0000;
      end else begin
         acc_q[0] <= acc_d[0];
         acc_q[1] <= acc_d[1];
      end
   end

   // -------------------------------------------------------------
   // temperature routing
   // -------------------------------------------------------------
   wire [8:0] filt_one = acc_q[0][15:7];
   wire [8:0] filt_two = acc_q[1][15:7];
   wire limit_use_one = smoothing_use_zone_one | limit_filter_sel_one;
   wire limit_use_two = smoothing_use_zone_two | limit_filter_sel_two;
   wire fan_use_one = smoothing_use_zone_one | fanctl_filter_sel_one;
   wire fan_use_two = smoothing_use_zone_two | fanctl_filter_sel_two;
   wire [8:0] fan_src_one = fan_use_one ? filt_one : zone_temp[8:0];
   wire [8:0] fan_src_two = fan_use_two ? filt_two : zone_temp[17:9];
   assign boost_src = {zone_temp[35:18], fan_src_two, fan_src_one};
   wire half_degree_pair_one = tach_res_q[fsc_pkg::HALF_DEG_ONE_BIT];
   wire half_degree_pair_two = tach_res_q[fsc_pkg::HALF_DEG_TWO_BIT];
   wire [8:0] res_mask_one = {8'hFF, half_degree_pair_one};
   wire [8:0] res_mask_two = {8'hFF, half_degree_pair_two};

   assign fanctl_temp[8:0] = fan_src_one & res_mask_one;
   assign fanctl_temp[17:9] = fan_src_two & res_mask_one;
   assign fanctl_temp[26:18] = zone_temp[26:18] & res_mask_two;
   assign fanctl_temp[35:27] = zone_temp[35:27] & res_mask_two;
   assign limit_temp = {limit_use_two ? filt_two : zone_temp[17:9],
                        limit_use_one ? filt_one : zone_temp[8:0]};
   assign reading_temp = zone_temp[17:0];
   assign filtered_temp = {filt_two, filt_one};

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   chk_tach_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_wr && hit_tach) |=> (smart_tach_en == $past(reg_wdata[3:0])))
      else $error("smart tach enables not updated by write");
   chk_thresh_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_rd && hit_thresh) |=> (reg_rdata[3:2] == 2'b00))
      else $error("reserved threshold bits read nonzero");
   chk_tach_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_rd && hit_tach) |=> (reg_rdata[7:6] == 2'b00))
      else $error("reserved tach mode bits read nonzero");
   chk_vid_select_out: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_wr && hit_thresh) |=> (cpu_a_vid_low_thresh == $past(reg_wdata[0]))
         && (cpu_b_vid_low_thresh == $past(reg_wdata[1])))
      else $error("vid threshold selects wrong");
   chk_hyst_b_reset: assert property (@(posedge clock)
      !rst_b |=> (hyst_b_q == 8'h44))
      else $error("zone 3/4 hysteresis reset value wrong");
   chk_boost_holds: assert property (@(posedge clock) disable iff (!rst_b)
      (boost_q[0] && boost_src[8:1] >= release_level(boost_temp[7:0], hyst_a_q[3:0]))
         |=> boost_q[0])
      else $error("boost released above release level");
   chk_fan_select_one: assert property (@(posedge clock) disable iff (!rst_b)
      (smoothing_use_zone_one && half_degree_pair_one) |-> (fanctl_temp[8:0] == filt_one))
      else $error("fan control not using filtered zone 1");
   chk_half_degree_off: assert property (@(posedge clock) disable iff (!rst_b)
      !half_degree_pair_two |-> (fanctl_temp[18] == 1'b0 && fanctl_temp[27] == 1'b0))
      else $error("half degree bit leaked on zones 3/4");
   chk_reading_raw: assert property (@(posedge clock) disable iff (!rst_b)
      smoothing_use_zone_two |-> (reading_temp[17:9] == zone_temp[17:9]))
      else $error("reading shows filtered value");
   chk_unit_tick_gap: assert property (@(posedge clock) disable iff (!rst_b)
      unit_tick_q |=> !unit_tick_q)
      else $error("delay unit tick too close");
endmodule // fsc_setup_regs
`default_nettype wire

//--- fan_setup_control_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fan_setup_control_regs_tb;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic temp_valid = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [1:0] regulator_hot_input = 2'h0;
   logic [1:0] cpu_throttle_signal = 2'h0;
   logic [35:0] zone_temp = 36'h0;
   logic [31:0] boost_temp = 32'h0;
   logic limit_filter_sel_one = 1'b0;
   logic limit_filter_sel_two = 1'b0;
   logic fanctl_filter_sel_one = 1'b0;
   logic fanctl_filter_sel_two = 1'b0;
   logic cpu_a_vid_low_thresh, cpu_b_vid_low_thresh;
   logic [3:0] smart_tach_en, gp_in_low_thresh, boost_full_duty;
   logic [7:0] reg_rdata, regulator_hot_duty, throttle_duty;
   logic [17:0] limit_temp, reading_temp, filtered_temp, old_filt;
   logic [35:0] fanctl_temp;
   logic [31:0] seed = 32'hEF13;
   logic [31:0] v;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   logic [7:0] ad [6] = '{8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC2};
   logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h00};
   logic [7:0] mk [6] = '{8'h3F, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] bt [3] = '{8'h3D, 8'h37, 8'h36};

   fsc_setup_regs #(.RAMP_UNIT_CYCLES(4)) dut (.clock, .rst_b, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .smart_tach_en, .cpu_a_vid_low_thresh, .cpu_b_vid_low_thresh,
      .gp_in_low_thresh, .regulator_hot_input, .cpu_throttle_signal, .regulator_hot_duty,
      .throttle_duty, .zone_temp, .boost_temp, .temp_valid, .limit_filter_sel_one,
      .limit_filter_sel_two, .fanctl_filter_sel_one, .fanctl_filter_sel_two, .fanctl_temp,
      .limit_temp, .reading_temp, .filtered_temp, .boost_full_duty);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      forever #12.5 clock = ~clock;
   end

   // hang guard well beyond the expected run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         tally_and_finish();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // half-degree bit kept only for zones whose pair select is set
   function automatic logic [35:0] fx(input logic [35:0] z, input logic [1:0] k);
      logic [35:0] r;
      r = z;
      for (int i = 0; i < 4; i++)
         if (!k[i / 2]) r[9 * i] = 1'b0;
      return r;
   endfunction

   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      chk("reg_rdata", {28'h0, e}, {28'h0, reg_rdata});
   endtask

   task automatic pulses(input int cnt);
      repeat (cnt) begin
         @(negedge clock);
         temp_valid = 1'b1;
         @(negedge clock);
         temp_valid = 1'b0;
      end
   endtask

   // cycles until the throttle duty next changes
   task automatic gap(output int c);
      logic [7:0] o;
      o = throttle_duty;
      c = 0;
      while (throttle_duty === o && c < 200) begin
         @(negedge clock);
         c++;
      end
   endtask

   task automatic tally_and_finish();
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clock);
      rst_b = 1'b1;
      for (int i = 0; i < 6; i++) rd(ad[i], rv[i]);
      for (int i = 0; i < 18; i++) begin
         v = xs();
         wr(ad[i % 6], v[7:0]);
         rd(ad[i % 6], v[7:0] & mk[i % 6]);
      end
      wr(8'hC3, 8'hFF);
      rd(8'hC3, 8'h00);
      v = xs();
      wr(8'hBD, v[7:0]);
      wr(8'hBE, v[15:8]);
      chk("smart_tach_en", {32'h0, v[3:0]}, {32'h0, smart_tach_en});
      chk("vid_thresh", {34'h0, v[9:8]}, {34'h0, cpu_b_vid_low_thresh, cpu_a_vid_low_thresh});
      chk("gp_thresh", {32'h0, v[15:12]}, {32'h0, gp_in_low_thresh});
      // fan control resolution for every pair setting
      wr(8'hC2, 8'h00);
      for (int k = 0; k < 4; k++) begin
         v = xs();
         zone_temp = {v[3:0], xs()};
         wr(8'hBD, {2'h0, k[1:0], 4'h0});
         chk("fanctl_temp", fx(zone_temp, k[1:0]), fanctl_temp);
      end
      // smoothing used, then only computed
      zone_temp = {18'h0, 9'h0A0, 9'h0C8};
      wr(8'hC2, 8'hFF);
      pulses(40);
      // a steady input is reached exactly by the settled filter
      chk("limit_filt", zone_temp, {18'h0, limit_temp});
      chk("filt_settled", zone_temp, {18'h0, filtered_temp});
      chk("reading_raw", zone_temp, {18'h0, reading_temp});
      wr(8'hC2, 8'h77);
      chk("limit_raw", zone_temp, {18'h0, limit_temp});
      old_filt = filtered_temp;
      zone_temp = {18'h0, 9'h050, 9'h064};
      pulses(4);
      chk("filt_moves", 36'h1, {35'h0, filtered_temp != old_filt});
      limit_filter_sel_one = 1'b1;
      @(negedge clock);
      chk("limit_sel", {27'h0, filtered_temp[8:0]}, {27'h0, limit_temp[8:0]});
      // ramp: regulator code 0 jumps, throttle code 2 steps every 8 cycles
      wr(8'hBF, 8'h20);
      regulator_hot_input = 2'b10;
      cpu_throttle_signal = 2'b01;
      @(negedge clock);
      chk("reg_hot_duty", 36'hFF, {28'h0, regulator_hot_duty});
      gap(n);
      v = {24'h0, throttle_duty};
      gap(n);
      chk("throttle_gap", 36'h8, 36'(n));
      chk("throttle_step", {28'h0, v[7:0] + 8'h01}, {28'h0, throttle_duty});
      regulator_hot_input = 2'b00;
      @(negedge clock);
      chk("reg_hot_off", 36'h0, {28'h0, regulator_hot_duty});
      // boost hold on zone three with hysteresis 5 below 60 degrees
      wr(8'hC1, 8'h35);
      boost_temp = 32'h003C_0000;
      for (int i = 0; i < 3; i++) begin
         zone_temp[26:18] = {bt[i], 1'b0};
         repeat (2) @(negedge clock);
         chk("boost_hold", {35'h0, i < 2}, {35'h0, boost_full_duty[2]});
      end
      tally_and_finish();
   end
endmodule // fan_setup_control_regs_tb
`default_nettype wire
